// *** src/iww_pkg.sv ***
package iww_pkg;

	// bus geometry
	localparam int          ADDR_W     = 8;
	localparam int          CNT_W      = 14;

	// register byte addresses
	localparam logic [7:0]  OFF_REFRESH = 8'h00;
	localparam logic [7:0]  OFF_STATUS  = 8'h04;
	localparam logic [7:0]  OFF_CTRL    = 8'h08;
	localparam logic [7:0]  OFF_RSTCTL  = 8'h0c;
	localparam logic [7:0]  OFF_LPCTL   = 8'h10;
	localparam logic [7:0]  OFF_NMIEN   = 8'h14;

	// field positions
	localparam int          CTRL_TIMEOUT_SELECT_LSB = 0;
	localparam int          CTRL_CKS_LSB  = 4;
	localparam int          CTRL_WINDOW_END_SELECT_LSB = 8;
	localparam int          CTRL_WINDOW_START_SELECT_LSB = 12;
	localparam int          RESET_OR_IRQ_SELECT_BIT   = 7;
	localparam int          LOW_POWER_COUNT_STOP_BIT    = 7;
	localparam int          NMIEN_BIT     = 0;
	localparam int          STAT_UF_BIT   = 14;
	localparam int          STAT_ERR_BIT  = 15;

	// reset values
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [7:0]  RSTCTL_RESET = 8'h00;
	localparam logic [7:0]  LPCTL_RESET  = 8'h00;
	localparam logic        NMIEN_RESET  = 1'b0;
	localparam logic [13:0] COUNT_RESET  = 14'h0000;

	// refresh key bytes
	localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
	localparam logic [7:0]  REFRESH_SECOND = 8'hff;

	// reload values per timeout select
	localparam logic [13:0] RELOAD_1K  = 14'h03ff;
	localparam logic [13:0] RELOAD_4K  = 14'h0fff;
	localparam logic [13:0] RELOAD_8K  = 14'h1fff;
	localparam logic [13:0] RELOAD_16K = 14'h3fff;

	// prescaler ratios
	localparam logic [8:0]  DIV_1   = 9'h001;
	localparam logic [8:0]  DIV_16  = 9'h010;
	localparam logic [8:0]  DIV_32  = 9'h020;
	localparam logic [8:0]  DIV_64  = 9'h040;
	localparam logic [8:0]  DIV_128 = 9'h080;
	localparam logic [8:0]  DIV_256 = 9'h100;

	// window quarter limits
	localparam logic [2:0]  QUARTERS = 3'h4;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [3:0] clock_divide_select;
		logic [1:0] timeout_select;
		logic [1:0] window_start_select;
		logic [1:0] window_end_select;
		logic       reset_or_irq_select;
		logic       low_power_count_stop;
	} iww_cfg_t;

	typedef enum logic [1:0] {ST_BOOT, ST_STOP, ST_RUN} iww_state_t;

	function automatic logic [13:0] iww_reload(input logic [1:0] timeout_select);
		case (timeout_select)
			2'b00:   return RELOAD_1K;
			2'b01:   return RELOAD_4K;
			2'b10:   return RELOAD_8K;
			default: return RELOAD_16K;
		endcase
	endfunction

endpackage

// *** src/iww_prescaler.sv ***
`timescale 1ns/1ps
module iww_prescaler
	import iww_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       dedClk,
	input  wire logic       run,
	input  wire logic [3:0] divSel,
	output logic            tick
);
	import iww_pkg::*;

	logic       dedPrev_reg;
	logic [8:0] preCnt_reg;
	logic       dedEdge;
	logic [8:0] ratio;

	// ratio decode; unlisted codes fall back to no division
	function automatic logic [8:0] divOf(input logic [3:0] sel);
		case (sel)
			4'h1:    return DIV_16;
			4'h2:    return DIV_32;
			4'h3:    return DIV_64;
			4'h4:    return DIV_128;
			4'h5:    return DIV_256;
			default: return DIV_1;
		endcase
	endfunction

	assign ratio   = divOf(divSel);
	assign dedEdge = dedClk & ~dedPrev_reg;

	// rising edges of the dedicated clock
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			dedPrev_reg <= 1'b0;
		else
			dedPrev_reg <= dedClk;
	end

	// divider restarts whenever counting is halted
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			preCnt_reg <= 9'h000;
			tick       <= 1'b0;
		end else if (!run) begin
			preCnt_reg <= 9'h000;
			tick       <= 1'b0;
		end else if (dedEdge) begin
			tick       <= (preCnt_reg == ratio - 9'h001);
			preCnt_reg <= (preCnt_reg == ratio - 9'h001) ? 9'h000
				: preCnt_reg + 9'h001;
		end else begin
			tick <= 1'b0;
		end
	end

endmodule // iww_prescaler

// *** src/iww_refresh_seq.sv ***
`timescale 1ns/1ps
module iww_refresh_seq
	import iww_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       wrStb,
	input  wire logic [7:0] wrData,
	output logic            refreshPulse
);
	import iww_pkg::*;

	logic armed_reg;

	// key byte must be the very next write after the arming byte
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_reg    <= 1'b0;
			refreshPulse <= 1'b0;
		end else begin
			refreshPulse <= wrStb & armed_reg
				& (wrData == REFRESH_SECOND);
			if (wrStb)
				armed_reg <= (wrData == REFRESH_FIRST);
		end
	end

endmodule // iww_refresh_seq

// *** src/iww_top.sv ***
`timescale 1ns/1ps
// Function
// - dedicated clock through 1..256 prescaler
// - 14-bit counter decrements per prescaled tick
// - auto-start counts right after reset release
// - refresh is 00h then FFh; starts register mode
// - reset stops and clears counter and registers
// - count-stop bit halts counting in low power
// - register mode stops on underflow or error
// - stopped counter resumes only after refresh
// - window start/end give refresh-permitted period
// - refresh outside window is error, like underflow
// - select bit: 1 reset, 0 interrupt
// - interrupt is NMI or maskable per enable
// - counter value readable in status register
// - timeout select picks 1K/4K/8K/16K period
// - separate underflow and refresh-error event pulses
// - outputs: reset, interrupt, count-stop control
// - auto mode takes settings from option word
// - register mode takes settings from registers
module iww_top
	import iww_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	input  wire logic              dedClk,
	input  wire logic              autoStartStrap,
	input  wire iww_pkg::iww_cfg_t optWord,
	input  wire logic              lowPowerMode,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   resetReq,
	output logic                   nmiReq,
	output logic                   irqReq,
	output logic                   countStop,
	output logic                   underflowEvt,
	output logic                   refreshErrEvt
);
	import iww_pkg::*;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	iww_state_t  state_reg;
	iww_cfg_t    act_reg;
	logic        autoMode_reg;
	logic [13:0] count_reg;
	logic [15:0] ctrl_reg;
	logic [7:0]  rstCtl_reg;
	logic [7:0]  lpCtl_reg;
	logic        nmiEn_reg;
	logic        ufFlag_reg;
	logic        errFlag_reg;
	logic [7:0]  awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	iww_cfg_t    regCfg;
	logic        doWrite;
	logic        wrMapped;
	logic        tick;
	logic        cntTick;
	logic        refreshPulse;
	logic        inRun;
	logic        permitted;
	logic        ufNow;
	logic        errNow;
	logic [15:0] startLim;
	logic [15:0] endLim;
	logic [31:0] rdMux;
	logic        rdMapped;
	logic [31:0] statusWord;

	// q quarters of the counting period, used for both window edges
	function automatic logic [15:0] winLimit(input logic [13:0] rl,
		input logic [2:0] q);
		logic [16:0] p;
		logic [19:0] m;
		p = {3'b000, rl} + 17'h00001;
		m = {3'b000, p} * {17'h00000, q};
		return m[17:2];
	endfunction

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// settings as software has them programmed
	assign regCfg.clock_divide_select     = ctrl_reg[CTRL_CKS_LSB +: 4];
	assign regCfg.timeout_select    = ctrl_reg[CTRL_TIMEOUT_SELECT_LSB +: 2];
	assign regCfg.window_start_select    = ctrl_reg[CTRL_WINDOW_START_SELECT_LSB +: 2];
	assign regCfg.window_end_select    = ctrl_reg[CTRL_WINDOW_END_SELECT_LSB +: 2];
	assign regCfg.reset_or_irq_select = rstCtl_reg[RESET_OR_IRQ_SELECT_BIT];
	assign regCfg.low_power_count_stop  = lpCtl_reg[LOW_POWER_COUNT_STOP_BIT];

	// window: start counts down from the top, end from zero
	assign startLim  = winLimit(iww_reload(act_reg.timeout_select),
		QUARTERS - {1'b0, act_reg.window_start_select});
	assign endLim    = winLimit(iww_reload(act_reg.timeout_select),
		{1'b0, act_reg.window_end_select});
	assign permitted = ({2'b00, count_reg} < startLim)
		&& ({2'b00, count_reg} >= endLim);

	assign inRun  = (state_reg == ST_RUN);
	// a tick already launched as the halt begins is dropped, not counted
	assign cntTick = tick & ~countStop;
	// a refresh in the same cycle blocks the tick's underflow; outside the window the tick still counts down
	assign errNow = inRun & refreshPulse & ~permitted;
	assign ufNow  = inRun & cntTick & ~refreshPulse
		& (count_reg == 14'h0000);

	// ---------------- AXI4-Lite slave ----------------

	assign doWrite  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wrMapped = (awAddr_reg == OFF_REFRESH)
		|| (awAddr_reg == OFF_STATUS) || (awAddr_reg == OFF_CTRL)
		|| (awAddr_reg == OFF_RSTCTL) || (awAddr_reg == OFF_LPCTL)
		|| (awAddr_reg == OFF_NMIEN);

	// address and data are caught separately, in either order
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awAddr_reg    <= 8'h00;
			wData_reg     <= 32'h0000_0000;
			wStrb_reg     <= 4'h0;
		end else if (doWrite) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awAddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wData_reg    <= s_axi_wdata;
				wStrb_reg    <= s_axi_wstrb;
			end
		end
	end

	// write response; unmapped addresses answer with a slave error
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control registers; in auto mode writes are stored, only the NMI enable takes effect
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg   <= CTRL_RESET;
			rstCtl_reg <= RSTCTL_RESET;
			lpCtl_reg  <= LPCTL_RESET;
			nmiEn_reg  <= NMIEN_RESET;
		end else if (doWrite) begin
			if (awAddr_reg == OFF_CTRL)
				ctrl_reg <= 16'(merge({16'h0000, ctrl_reg}, wData_reg,
					wStrb_reg));
			if (awAddr_reg == OFF_RSTCTL && wStrb_reg[0])
				rstCtl_reg <= wData_reg[7:0];
			if (awAddr_reg == OFF_LPCTL && wStrb_reg[0])
				lpCtl_reg <= wData_reg[7:0];
			if (awAddr_reg == OFF_NMIEN && wStrb_reg[0])
				nmiEn_reg <= wData_reg[NMIEN_BIT];
		end
	end

	// sticky event flags: write one to clear, a new event wins
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ufFlag_reg  <= 1'b0;
			errFlag_reg <= 1'b0;
		end else begin
			if (ufNow)
				ufFlag_reg <= 1'b1;
			else if (doWrite && awAddr_reg == OFF_STATUS
				&& wStrb_reg[1] && wData_reg[STAT_UF_BIT])
				ufFlag_reg <= 1'b0;
			if (errNow)
				errFlag_reg <= 1'b1;
			else if (doWrite && awAddr_reg == OFF_STATUS
				&& wStrb_reg[1] && wData_reg[STAT_ERR_BIT])
				errFlag_reg <= 1'b0;
		end
	end

	// read decode; refresh register reads as zero
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[13:0] = count_reg;
		statusWord[STAT_UF_BIT]  = ufFlag_reg;
		statusWord[STAT_ERR_BIT] = errFlag_reg;
		rdMux    = 32'h0000_0000;
		rdMapped = 1'b1;
		case (s_axi_araddr)
			OFF_REFRESH: rdMux = 32'h0000_0000;
			OFF_STATUS:  rdMux = statusWord;
			OFF_CTRL:    rdMux = {16'h0000, ctrl_reg};
			OFF_RSTCTL:  rdMux = {24'h000000, rstCtl_reg};
			OFF_LPCTL:   rdMux = {24'h000000, lpCtl_reg};
			OFF_NMIEN:   rdMux = {31'h00000000, nmiEn_reg};
			default:     rdMapped = 1'b0;
		endcase
	end

	// read channel answers one cycle after the address is taken
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdMux;
			s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------- watchdog core ----------------

	iww_refresh_seq u_refresh (
		.ref_clk      (ref_clk),
		.reset_n      (reset_n),
		.wrStb        (doWrite && awAddr_reg == OFF_REFRESH
			&& wStrb_reg[0]),
		.wrData       (wData_reg[7:0]),
		.refreshPulse (refreshPulse)
	);

	iww_prescaler u_presc (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.dedClk  (dedClk),
		.run     (inRun & ~countStop),
		.divSel  (act_reg.clock_divide_select),
		.tick    (tick)
	);

	// start-mode strap is sampled in the first cycle after release
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			autoMode_reg <= 1'b0;
		else if (state_reg == ST_BOOT)
			autoMode_reg <= autoStartStrap;
	end

	// run state; only register mode ever parks in stop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_BOOT;
		end else begin
			case (state_reg)
				ST_BOOT:
					state_reg <= autoStartStrap ? ST_RUN : ST_STOP;
				ST_RUN:
					if (!autoMode_reg && (ufNow || errNow))
						state_reg <= ST_STOP;
				ST_STOP:
					if (refreshPulse)
						state_reg <= ST_RUN;
				default:
					state_reg <= ST_BOOT;
			endcase
		end
	end

	// active settings: option word at boot or registers at start
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			act_reg <= '0;
		else if (state_reg == ST_BOOT && autoStartStrap)
			act_reg <= optWord;
		else if (state_reg == ST_STOP && refreshPulse)
			act_reg <= regCfg;
	end

	// down-counter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= COUNT_RESET;
		end else begin
			case (state_reg)
				ST_BOOT:
					if (autoStartStrap)
						count_reg <= iww_reload(optWord.timeout_select);
				ST_STOP:
					if (refreshPulse)
						count_reg <= iww_reload(regCfg.timeout_select);
				ST_RUN:
					if (refreshPulse && permitted)
						count_reg <= iww_reload(act_reg.timeout_select);
					else if (ufNow && autoMode_reg)
						count_reg <= iww_reload(act_reg.timeout_select);
					else if (cntTick && count_reg != 14'h0000)
						count_reg <= count_reg - 14'h0001;
				default:
					count_reg <= COUNT_RESET;
			endcase
		end
	end

	// low-power halt control, only while a low-power mode is held
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			countStop <= 1'b0;
		else
			countStop <= lowPowerMode & act_reg.low_power_count_stop;
	end

	// separate event-link pulses
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			underflowEvt  <= 1'b0;
			refreshErrEvt <= 1'b0;
		end else begin
			underflowEvt  <= ufNow;
			refreshErrEvt <= errNow;
		end
	end

	// action: reset holds until the chip resets, interrupts pulse
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			resetReq <= 1'b0;
			nmiReq   <= 1'b0;
			irqReq   <= 1'b0;
		end else begin
			if ((ufNow || errNow) && act_reg.reset_or_irq_select)
				resetReq <= 1'b1;
			nmiReq <= (ufNow || errNow) & ~act_reg.reset_or_irq_select
				& nmiEn_reg;
			irqReq <= (ufNow || errNow) & ~act_reg.reset_or_irq_select
				& ~nmiEn_reg;
		end
	end

	// ---------------- checks ----------------

	refresh_reload_a: assert property (
		inRun && refreshPulse && permitted
		|=> count_reg == iww_reload(act_reg.timeout_select))
		else $error("refresh inside window did not reload");

	refresh_error_a: assert property (
		inRun && refreshPulse && !permitted
		|=> refreshErrEvt && !underflowEvt)
		else $error("refresh outside window not flagged");

	count_step_a: assert property (
		inRun && cntTick && !refreshPulse && count_reg != 14'h0000
		|=> count_reg == $past(count_reg) - 14'h0001)
		else $error("counter did not step down by one");

	underflow_evt_a: assert property (
		inRun && cntTick && !refreshPulse && count_reg == 14'h0000
		|=> underflowEvt ##1 !underflowEvt)
		else $error("underflow pulse missing or too long");

	regmode_stop_a: assert property (
		!autoMode_reg && (underflowEvt || refreshErrEvt)
		|-> state_reg == ST_STOP)
		else $error("register mode kept counting after event");

	stop_hold_a: assert property (
		state_reg == ST_STOP && !refreshPulse
		|=> state_reg == ST_STOP)
		else $error("stopped counter resumed without refresh");

	lp_halt_a: assert property (
		countStop && inRun && !refreshPulse
		|=> $stable(count_reg))
		else $error("counter moved during low-power halt");

	reset_sel_a: assert property (
		(ufNow || errNow) && act_reg.reset_or_irq_select
		|=> resetReq && !nmiReq && !irqReq)
		else $error("reset action not taken");

	irq_sel_a: assert property (
		(ufNow || errNow) && !act_reg.reset_or_irq_select
		|=> (nmiReq == nmiEn_reg) && (irqReq == !nmiEn_reg))
		else $error("wrong interrupt kind");

	auto_start_a: assert property (
		state_reg == ST_BOOT && autoStartStrap
		|=> inRun ##1 inRun)
		else $error("auto mode did not start");

	bvalid_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");

	underflow_c: cover property (underflowEvt);
	refresh_ok_c: cover property (inRun && refreshPulse && permitted);
	refresh_err_c: cover property (refreshErrEvt);
	restart_c: cover property (state_reg == ST_STOP ##1 inRun);

endmodule // iww_top

// *** bench/iww_tb_top.sv ***
`timescale 1ns/1ps
module iww_tb_top;
	import iww_pkg::*;

	typedef struct {
		logic [31:0] exp;
		logic [31:0] msk;
	} iww_note_t;

	logic        ref_clk, reset_n, dedClk, dPhase, autoStartStrap;
	logic        lowPowerMode, resetReq, nmiReq, irqReq, countStop;
	logic        underflowEvt, refreshErrEvt;
	iww_cfg_t    optWord;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, d0, d1;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	iww_note_t   rdq[$];
	iww_note_t   ent;
	logic [3:0]  evq[$];
	int          failCount = 0;
	int          nChecks = 0;
	logic [7:0]  offs[5] = '{OFF_STATUS, OFF_CTRL, OFF_RSTCTL, OFF_LPCTL,
		OFF_NMIEN};
	logic [31:0] bits[5] = '{32'h0, 32'h0, 32'h80, 32'h80, 32'h1};

	iww_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .dedClk(dedClk),
		.autoStartStrap(autoStartStrap), .optWord(optWord),
		.lowPowerMode(lowPowerMode), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.resetReq(resetReq), .nmiReq(nmiReq), .irqReq(irqReq),
		.countStop(countStop), .underflowEvt(underflowEvt),
		.refreshErrEvt(refreshErrEvt));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// dedicated clock at a quarter of ref_clk, slow enough to be sampled
	always @(posedge ref_clk) begin
		dPhase <= ~dPhase;
		if (dPhase)
			dedClk <= ~dedClk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic stopTest();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// every wait is bounded; running out ends the run as a mismatch
	task automatic guard(ref int i, input int lim);
		i++;
		if (i > lim) begin
			failCount++;
			stopTest();
		end
	endtask

	// monitor: pops the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
			ent = rdq.pop_front();
			check("read data", s_axi_rdata & ent.msk, ent.exp);
		end
		if ((underflowEvt | refreshErrEvt | nmiReq | irqReq) === 1'b1)
			check("event pulses", {underflowEvt, refreshErrEvt, nmiReq,
				irqReq}, evq.pop_front());
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [1:0] resp);
		int   i;
		logic aw, w;
		i = 0;
		aw = 1'b1;
		w = 1'b1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw | w) begin
			@(posedge ref_clk);
			if (aw && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w = 1'b0;
			end
			guard(i, 100);
		end
		do begin
			@(posedge ref_clk);
			guard(i, 100);
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("write response", {30'h0, s_axi_bresp}, {30'h0, resp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] msk, input logic [1:0] resp,
		output logic [31:0] d);
		int i;
		i = 0;
		rdq.push_back('{exp, msk});
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			guard(i, 100);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge ref_clk);
			guard(i, 100);
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		check("read response", {30'h0, s_axi_rresp}, {30'h0, resp});
	endtask

	task automatic refresh();
		wr(OFF_REFRESH, 32'h00, 4'h1, RESP_OKAY);
		wr(OFF_REFRESH, 32'hff, 4'h1, RESP_OKAY);
	endtask

	task automatic wait_q(input int lim);
		int i;
		i = 0;
		while (evq.size() != 0) begin
			@(negedge ref_clk);
			guard(i, lim);
		end
	endtask

	task automatic do_reset(input logic strap, input iww_cfg_t opt);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		autoStartStrap <= strap;
		optWord <= opt;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask

	task automatic set_lp(input logic v);
		@(posedge ref_clk);
		lowPowerMode <= v;
		repeat (3) @(negedge ref_clk);
	endtask

	initial begin
		{reset_n, dedClk, dPhase, autoStartStrap, lowPowerMode} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_wstrb} = '0;
		seed = lfsr(32'h2009);
		optWord = iww_cfg_t'(seed[11:0]);
		// register start mode; option word must be ignored
		do_reset(1'b0, iww_cfg_t'(seed[11:0]));
		foreach (offs[k])
			rd(offs[k], 32'h0, 32'hffffffff, RESP_OKAY, d0);
		rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR, d0);
		wr(8'h40, 32'h1, 4'hf, RESP_SLVERR);
		// broken key pair must leave the stopped counter at zero
		wr(OFF_REFRESH, 32'h00, 4'h1, RESP_OKAY);
		wr(OFF_REFRESH, 32'h55, 4'h1, RESP_OKAY);
		wr(OFF_REFRESH, 32'hff, 4'h1, RESP_OKAY);
		repeat (40) @(negedge ref_clk);
		rd(OFF_STATUS, 32'h0, 32'h3fff, RESP_OKAY, d0);
		// control fields read back; random pattern
		seed = lfsr(seed);
		wr(OFF_CTRL, seed & 32'h33f3, 4'hf, RESP_OKAY);
		rd(OFF_CTRL, seed & 32'h33f3, 32'hffff, RESP_OKAY, d0);
		for (int k = 2; k < 5; k++) begin
			wr(offs[k], bits[k], 4'h1, RESP_OKAY);
			rd(offs[k], bits[k], 32'hff, RESP_OKAY, d0);
			wr(offs[k], 32'h0, 4'h1, RESP_OKAY);
		end
		// shortest period, nmi route, start by refresh
		wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
		wr(OFF_NMIEN, 32'h1, 4'h1, RESP_OKAY);
		refresh();
		rd(OFF_STATUS, 32'h0, 32'h3c00, RESP_OKAY, d0);
		set_lp(1'b1);
		check("count stop", countStop, 1'b0);
		set_lp(1'b0);
		evq.push_back(4'b1010);
		wait_q(6000);
		repeat (50) @(negedge ref_clk);
		rd(OFF_STATUS, 32'h4000, 32'h7fff, RESP_OKAY, d0);
		check("reset request", resetReq, 1'b0);
		wr(OFF_STATUS, 32'h4000, 4'h2, RESP_OKAY);
		// longest period, divide by 16, late window start; restart
		wr(OFF_CTRL, 32'h3013, 4'hf, RESP_OKAY);
		wr(OFF_NMIEN, 32'h0, 4'h1, RESP_OKAY);
		refresh();
		rd(OFF_STATUS, 32'h2000, 32'h6000, RESP_OKAY, d0);
		// one tick per 16 dedicated edges: 4 or 5 ticks in ~259 cycles
		repeat (256) @(negedge ref_clk);
		rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d1);
		check("divided count", 32'((d0[13:0] - d1[13:0])
			inside {[14'h3:14'h5]}), 32'h1);
		// count near the top is outside the window: maskable interrupt
		evq.push_back(4'b0101);
		refresh();
		wait_q(100);
		rd(OFF_STATUS, 32'h8000, 32'h8000, RESP_OKAY, d0);
		rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d0);
		repeat (40) @(negedge ref_clk);
		rd(OFF_STATUS, d0 & 32'h3fff, 32'h3fff, RESP_OKAY, d1);
		// auto start from option word: reset action, stop in low power
		do_reset(1'b1, iww_cfg_t'(12'h003));
		@(negedge ref_clk);
		check("reset request", resetReq, 1'b0);
		rd(OFF_STATUS, 32'h0, 32'h3c00, RESP_OKAY, d0);
		repeat (40) @(negedge ref_clk);
		rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d1);
		check("auto counting", 32'(d1[13:0] < d0[13:0]), 32'h1);
		// full window: a refresh now must reload the count
		refresh();
		rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d0);
		check("refresh reload", 32'(d0[13:0] > d1[13:0]), 32'h1);
		set_lp(1'b1);
		check("count stop", countStop, 1'b1);
		rd(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY, d0);
		repeat (40) @(negedge ref_clk);
		rd(OFF_STATUS, d0 & 32'h3fff, 32'h3fff, RESP_OKAY, d1);
		set_lp(1'b0);
		evq.push_back(4'b1000);
		wait_q(6000);
		@(negedge ref_clk);
		check("reset request", resetReq, 1'b1);
		stopTest();
	end
endmodule // iww_tb_top
